/* File: hdl/cfsp_defines.vh */
`ifndef CFSP_DEFINES_VH
`define CFSP_DEFINES_VH

// serial opcodes
`define CFSP_OP_WRITE 8'h02
`define CFSP_OP_READ 8'h03

// byte addresses of the four 24-bit registers (high byte first)
`define CFSP_ADDR_CONTROL 8'h00
`define CFSP_ADDR_COMMAND 8'h03
`define CFSP_ADDR_DATA_FIRST 8'h06
`define CFSP_ADDR_DATA_SECOND 8'h09
`define CFSP_ADDR_LAST 8'h0b
`define CFSP_NUM_BYTES 12

// special byte locations
`define CFSP_ADDR_CTRL_MID 8'h01
`define CFSP_ADDR_CMD_LOW 8'h05
`define CFSP_ADDR_DAT1_LOW 8'h08

// array indices of the data-first register bytes
`define CFSP_IDX_DAT1_HIGH 6
`define CFSP_IDX_DAT1_MID 7
`define CFSP_IDX_DAT1_LOW 8

// command_pending bit position inside the control mid byte
`define CFSP_PENDING_BIT 0

// reset value of every register byte
`define CFSP_BYTE_RESET 8'h00

// command code whose completion returns a value into data-first
`define CFSP_CMD_READ_REG 24'h000002

// timing
`define CFSP_CLK_MHZ 20
`define CFSP_SCK_MAX_KHZ 4096
`define CFSP_READY_NS 1000
`define CFSP_READY_CYCLES ((`CFSP_READY_NS * `CFSP_CLK_MHZ) / 1000)
`define CFSP_BOOT_SETTLE 2'd3

`endif

/* File: hdl/cfsp_sync.v */
`timescale 1ns/1ns

module cfsp_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // asynchronous levels in, synchronised levels out
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_r;
   reg [WIDTH-1:0] stage2_r;

   // first stage feeds only the second one
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_r <= RESET_VAL;
         stage2_r <= RESET_VAL;
      end else begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
      end
   end

   assign syncOut = stage2_r;

endmodule

/* File: hdl/cfsp_port.v */
`timescale 1ns/1ns
`include "cfsp_defines.vh"

// What this block does
// R1: after reset sample boot select; low means microcontroller feeds commands here
// R2: in microcontroller boot the unused port pins stay inactive
// R3: active-low port select frames each whole serial transaction
// R4: master keeps the serial clock at or below 4.096 MHz
// R5: master changes data on falling edges; device captures on rising edges
// R6: device changes open-drain data out on falling edges, pulling low only
// R7: ready_pulse_n gives a 1 us low pulse when ready for more
// R8: opcode then address byte; 0x02 writes, 0x03 reads from that address
// R9: each further data byte goes to the next byte address in turn
// R10: four 24-bit registers, three bytes each, high mid low, 8-bit space
// R11: one write may carry command plus two data words in sequence
// R12: writes are normally 5, 8 or 11 bytes to command or data-first
// R13: reads are 3 or 5 bytes; register bytes return during filler bytes
// R14: later data-first writes append extra words to the pending command
// R15: master waits 1 ms, watches the pulse, or polls pending between commands
// R16: ready pulse only after the current command has finished
// R17: command_pending in control mid byte reads 1 while busy, 0 when free
// R18: control mid byte read is served at any moment
// R19: a register-read command returns its value into the data-first register
// R20: bytes travel most significant bit first, eight clocks per byte
// R21: finishing a command write starts it and sets pending until done
module cfsp_port (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // boot strap
   input wire bootSelect,
   output wire mcuBootMode,
   // serial port pins
   input wire portSelectN,
   input wire portSerialClock,
   input wire mosi,
   output wire misoOut,
   output wire misoOe,
   output wire readyPulseN,
   output wire eepromSelectN,
   // filter core side
   output wire coreCmdStart,
   output wire coreCmdAppend,
   output wire [23:0] coreControl,
   output wire [23:0] coreCommand,
   output wire [23:0] coreDataFirst,
   output wire [23:0] coreDataSecond,
   output wire coreCmdPending,
   input wire coreDone,
   input wire [23:0] coreReadData
);

   localparam [1:0] ST_OPCODE = 2'd0;
   localparam [1:0] ST_ADDR = 2'd1;
   localparam [1:0] ST_DATA = 2'd2;
   localparam [1:0] ST_IGNORE = 2'd3;
   // 1 us in system clocks, sized to the counter width; 20 fits in 5 bits
   localparam integer READY_FULL = `CFSP_READY_CYCLES;
   localparam [4:0] READY_LOAD = READY_FULL[4:0];

   integer i;

   wire [3:0] pinSync;
   wire bootS;
   wire ssnS;
   wire sckS;
   wire mosiS;

   reg sckD_r;
   reg ssnD_r;
   reg [1:0] bootCnt_r;
   reg bootDone_r;
   reg mcuMode_r;

   reg [1:0] state_r;
   reg [2:0] bitCnt_r;
   reg [7:0] rxShift_r;
   reg [7:0] addrPtr_r;
   reg isRead_r;
   reg cmdWritten_r;
   reg dat1Written_r;
   reg [7:0] regFile [0:`CFSP_NUM_BYTES-1];

   reg [7:0] txShift_r;
   reg misoLow_r;

   reg cmdStart_r;
   reg cmdAppend_r;
   reg pending_r;
   reg pending_nxt;
   reg [4:0] readyCnt_r;
   reg [4:0] readyCnt_nxt;
   reg readyPulseN_r;
   reg eepromSelectN_r;

   wire portActive;
   wire sckRise;
   wire sckFall;
   wire ssnRise;
   wire [7:0] rxByte;
   wire addrInMap;
   wire startAny;
   wire readCmd;
   reg [7:0] txByte;

   // pins pass two flops; idle levels: select high, boot high
   cfsp_sync #(
      .WIDTH(4),
      .RESET_VAL(4'hc)
   ) u_pinSync (
      .clk(clk),
      .reset_n(reset_n),
      .asyncIn({bootSelect, portSelectN, portSerialClock, mosi}),
      .syncOut(pinSync)
   );

   assign bootS = pinSync[3];
   assign ssnS = pinSync[2];
   assign sckS = pinSync[1];
   assign mosiS = pinSync[0];

   // edge detection on synchronised levels only
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sckD_r <= 1'b0;
         ssnD_r <= 1'b1;
      end else begin
         sckD_r <= sckS;
         ssnD_r <= ssnS;
      end
   end

   // strap caught a few cycles after release so the syncer has settled
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bootCnt_r <= 2'd0;
         bootDone_r <= 1'b0;
         mcuMode_r <= 1'b0;
      end else if (!bootDone_r) begin
         if (bootCnt_r == `CFSP_BOOT_SETTLE) begin
            bootDone_r <= 1'b1;
            mcuMode_r <= ~bootS; // R1
         end else begin
            bootCnt_r <= bootCnt_r + 2'd1;
         end
      end
   end

   // select framing gates all serial activity
   assign portActive = mcuMode_r & ~ssnS; // R3
   assign sckRise = portActive & sckS & ~sckD_r; // R5
   assign sckFall = portActive & ~sckS & sckD_r; // R6
   assign ssnRise = mcuMode_r & ssnS & ~ssnD_r;
   assign rxByte = {rxShift_r[6:0], mosiS}; // R20
   assign addrInMap = (addrPtr_r <= `CFSP_ADDR_LAST);
   assign startAny = cmdStart_r | cmdAppend_r;
   assign readCmd = (coreCommand == `CFSP_CMD_READ_REG);

   // byte returned on a read; pending bit is live state, never stored
   always @* begin
      if (addrPtr_r == `CFSP_ADDR_CTRL_MID) begin
         txByte = {regFile[1][7:1], pending_r}; // R17 R18
      end else if (addrInMap) begin
         txByte = regFile[addrPtr_r[3:0]];
      end else begin
         txByte = 8'h00;
      end
   end

   // receive side, register writes and command hand-off
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_OPCODE;
         bitCnt_r <= 3'd0;
         rxShift_r <= 8'h00;
         addrPtr_r <= 8'h00;
         isRead_r <= 1'b0;
         cmdWritten_r <= 1'b0;
         dat1Written_r <= 1'b0;
         cmdStart_r <= 1'b0;
         cmdAppend_r <= 1'b0;
         for (i = 0; i < `CFSP_NUM_BYTES; i = i + 1) begin
            regFile[i] <= `CFSP_BYTE_RESET;
         end
      end else begin
         cmdStart_r <= 1'b0;
         cmdAppend_r <= 1'b0;
         if (!portActive) begin
            // a partial byte is dropped when select rises
            state_r <= ST_OPCODE;
            bitCnt_r <= 3'd0;
         end else if (sckRise) begin
            rxShift_r <= rxByte;
            bitCnt_r <= bitCnt_r + 3'd1;
            if (bitCnt_r == 3'd7) begin
               case (state_r)
                  ST_OPCODE: begin
                     if (rxByte == `CFSP_OP_WRITE) begin // R8
                        isRead_r <= 1'b0;
                        state_r <= ST_ADDR;
                     end else if (rxByte == `CFSP_OP_READ) begin // R8
                        isRead_r <= 1'b1;
                        state_r <= ST_ADDR;
                     end else begin
                        state_r <= ST_IGNORE;
                     end
                  end
                  ST_ADDR: begin
                     addrPtr_r <= rxByte; // R8
                     state_r <= ST_DATA;
                  end
                  ST_DATA: begin
                     if (!isRead_r && addrInMap) begin
                        if (addrPtr_r == `CFSP_ADDR_CTRL_MID) begin
                           // pending bit is read only
                           regFile[1] <= {rxByte[7:1], 1'b0};
                        end else begin
                           regFile[addrPtr_r[3:0]] <= rxByte; // R10 R11
                        end
                        if (addrPtr_r == `CFSP_ADDR_CMD_LOW) begin
                           cmdWritten_r <= 1'b1; // R21
                        end
                        if (addrPtr_r == `CFSP_ADDR_DAT1_LOW) begin
                           dat1Written_r <= 1'b1; // R14
                        end
                     end
                     addrPtr_r <= addrPtr_r + 8'h01; // R9
                  end
                  default: begin
                     state_r <= ST_IGNORE;
                  end
               endcase
            end
         end
         // work is handed over only once the frame has closed
         if (ssnRise) begin
            if (cmdWritten_r) begin
               cmdStart_r <= 1'b1; // R21
            end else if (dat1Written_r) begin
               cmdAppend_r <= 1'b1; // R14
            end
            cmdWritten_r <= 1'b0;
            dat1Written_r <= 1'b0;
         end
         // core answer lands in data-first; a serial write in the same
         // cycle loses, which only happens if the master ignores busy
         if (coreDone && pending_r && readCmd) begin
            regFile[`CFSP_IDX_DAT1_HIGH] <= coreReadData[23:16]; // R19
            regFile[`CFSP_IDX_DAT1_MID] <= coreReadData[15:8]; // R19
            regFile[`CFSP_IDX_DAT1_LOW] <= coreReadData[7:0]; // R19
         end
      end
   end

   // transmit side: change on falling edge, valid at next rising edge
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txShift_r <= 8'h00;
         misoLow_r <= 1'b0;
      end else if (!portActive) begin
         misoLow_r <= 1'b0; // R2
      end else if (sckFall) begin
         if (state_r == ST_DATA && isRead_r) begin
            if (bitCnt_r == 3'd0) begin
               // whole byte latched so a live pending bit cannot tear
               txShift_r <= {txByte[6:0], 1'b0}; // R13 R20
               misoLow_r <= ~txByte[7]; // R6
            end else begin
               txShift_r <= {txShift_r[6:0], 1'b0}; // R20
               misoLow_r <= ~txShift_r[7]; // R6
            end
         end else begin
            misoLow_r <= 1'b0;
         end
      end
   end

   // pending: a start in the done cycle keeps it set
   always @* begin
      pending_nxt = pending_r;
      if (startAny) begin
         pending_nxt = 1'b1; // R21
      end else if (coreDone) begin
         pending_nxt = 1'b0; // R17
      end
   end

   // ready pulse counts from the end of processing
   always @* begin
      readyCnt_nxt = readyCnt_r;
      if (coreDone && pending_r && !startAny) begin
         readyCnt_nxt = READY_LOAD; // R16
      end else if (readyCnt_r != 5'd0) begin
         readyCnt_nxt = readyCnt_r - 5'd1;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pending_r <= 1'b0;
         readyCnt_r <= 5'd0;
         readyPulseN_r <= 1'b1;
         eepromSelectN_r <= 1'b1;
      end else begin
         pending_r <= pending_nxt;
         readyCnt_r <= readyCnt_nxt;
         readyPulseN_r <= (readyCnt_nxt == 5'd0); // R7
         eepromSelectN_r <= 1'b1; // R2
      end
   end

   // open drain: only ever pulls low
   assign misoOut = 1'b0;
   assign misoOe = misoLow_r; // R6
   assign readyPulseN = readyPulseN_r;
   assign eepromSelectN = eepromSelectN_r;
   assign mcuBootMode = mcuMode_r;

   assign coreCmdStart = cmdStart_r;
   assign coreCmdAppend = cmdAppend_r;
   assign coreCmdPending = pending_r;
   assign coreControl = {regFile[0], regFile[1][7:1], pending_r,
      regFile[2]};
   assign coreCommand = {regFile[3], regFile[4], regFile[5]};
   assign coreDataFirst = {regFile[6], regFile[7], regFile[8]};
   assign coreDataSecond = {regFile[9], regFile[10], regFile[11]};

endmodule

/* File: bench/cfsp_port_asserts.sv */
`timescale 1ns/1ns
module cfsp_port_asserts (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // pins
   input wire mcuBootMode,
   input wire portSelectN,
   input wire misoOut,
   input wire misoOe,
   input wire readyPulseN,
   input wire eepromSelectN,
   // core side
   input wire coreCmdStart,
   input wire coreCmdAppend,
   input wire [23:0] coreControl,
   input wire coreCmdPending,
   input wire coreDone
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // low cycles of the ready pulse; saturation not needed, pulse is short
   reg [5:0] lowCnt_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         lowCnt_r <= 6'h00;
      else if (readyPulseN)
         lowCnt_r <= 6'h00;
      else
         lowCnt_r <= lowCnt_r + 6'h01;
   end
   property p_idle; eepromSelectN && !misoOut; endproperty
   a_idle: assert property (p_idle) else $error("pin not idle");
   property p_boot;
      !mcuBootMode |-> !misoOe && !coreCmdStart && !coreCmdAppend;
   endproperty
   a_boot: assert property (p_boot) else $error("port active");
   property p_sel; portSelectN [*5] |-> !misoOe; endproperty
   a_sel: assert property (p_sel) else $error("miso driven");
   property p_width; $rose(readyPulseN) |-> lowCnt_r == 6'd20; endproperty
   a_width: assert property (p_width) else $error("pulse width");
   property p_wmax; !readyPulseN |-> lowCnt_r < 6'd20; endproperty
   a_wmax: assert property (p_wmax) else $error("pulse long");
   property p_cause;
      $fell(readyPulseN) |-> $past(coreDone) && $past(coreCmdPending);
   endproperty
   a_cause: assert property (p_cause) else $error("early pulse");
   property p_done;
      coreDone && coreCmdPending && !coreCmdStart && !coreCmdAppend
         |=> !coreCmdPending && !readyPulseN;
   endproperty
   a_done: assert property (p_done) else $error("done lost");
   property p_start; coreCmdStart |=> coreCmdPending; endproperty
   a_start: assert property (p_start) else $error("no pending");
   property p_frame;
      (coreCmdStart || coreCmdAppend) |-> portSelectN;
   endproperty
   a_frame: assert property (p_frame) else $error("mid frame");
   property p_excl; !(coreCmdStart && coreCmdAppend); endproperty
   a_excl: assert property (p_excl) else $error("both pulses");
   property p_bit; coreControl[8] == coreCmdPending; endproperty
   a_bit: assert property (p_bit) else $error("pending bit");
   c_start: cover property (coreCmdStart);
   c_app: cover property (coreCmdAppend);
   c_ready: cover property ($fell(readyPulseN));
endmodule
bind cfsp_port cfsp_port_asserts u_chk (.clk(clk), .reset_n(reset_n),
   .mcuBootMode(mcuBootMode), .portSelectN(portSelectN),
   .misoOut(misoOut), .misoOe(misoOe), .readyPulseN(readyPulseN),
   .eepromSelectN(eepromSelectN), .coreCmdStart(coreCmdStart),
   .coreCmdAppend(coreCmdAppend), .coreControl(coreControl),
   .coreCmdPending(coreCmdPending), .coreDone(coreDone));

/* File: bench/cfsp_mcu_model.sv */
`timescale 1ns/1ns
module cfsp_mcu_model (
   // clock
   input wire clk,
   // serial pins
   output reg selN,
   output reg sck,
   output reg mosi,
   input wire miso
);
   integer i;
   initial begin
      selN = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   task hold(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // 400 ns period keeps the clock under the 4.096 MHz ceiling
   task xbyte(input [7:0] tx, output [7:0] rx);
      for (i = 7; i >= 0; i = i - 1) begin
         mosi <= tx[i];
         hold(4);
         sck <= 1'b1;
         rx[i] = miso;
         hold(4);
         sck <= 1'b0;
      end
   endtask
   task frameOpen;
      selN <= 1'b0;
      hold(4);
   endtask
   // released data line flips so stale bits cannot pass
   task frameClose;
      hold(4);
      selN <= 1'b1;
      mosi <= ~mosi;
      hold(8);
   endtask
endmodule

/* File: bench/tb_cfsp_port.sv */
`timescale 1ns/1ns
module tb_cfsp_port;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg bootSelect = 1'b0;
   reg coreDone = 1'b0;
   reg [23:0] coreReadData = 24'h000000;
   wire selN, sck, mosi, misoOut, misoOe, readyPulseN, mcuBootMode;
   wire eepromSelectN, coreCmdStart, coreCmdAppend, coreCmdPending;
   wire [23:0] coreControl, coreCommand, coreDataFirst, coreDataSecond;
   wire miso = misoOe ? misoOut : 1'b1; // pull-up when released
   integer miscompares = 0;
   integer compares = 0;
   integer cycles = 0;
   integer k;
   reg [23:0] starts = 24'h0;
   reg [23:0] apps = 24'h0;
   reg [23:0] seenS = 24'h0;
   reg [23:0] seenA = 24'h0;
   reg [87:0] r;
   reg [7:0] b;
   always #25 clk = ~clk;
   // pulses last one cycle and end before a frame task returns
   always @(posedge clk) begin
      if (coreCmdStart === 1'b1)
         starts <= starts + 24'h1;
      if (coreCmdAppend === 1'b1)
         apps <= apps + 24'h1;
   end
   cfsp_port dut (.clk(clk), .reset_n(reset_n), .bootSelect(bootSelect),
      .mcuBootMode(mcuBootMode), .portSelectN(selN),
      .portSerialClock(sck), .mosi(mosi), .misoOut(misoOut),
      .misoOe(misoOe), .readyPulseN(readyPulseN),
      .eepromSelectN(eepromSelectN), .coreCmdStart(coreCmdStart),
      .coreCmdAppend(coreCmdAppend), .coreControl(coreControl),
      .coreCommand(coreCommand), .coreDataFirst(coreDataFirst),
      .coreDataSecond(coreDataSecond), .coreCmdPending(coreCmdPending),
      .coreDone(coreDone), .coreReadData(coreReadData));
   cfsp_mcu_model u_mst (.clk(clk), .selN(selN), .sck(sck),
      .mosi(mosi), .miso(miso));
   task chk(input [79:0] name, input [23:0] exp, input [23:0] got);
      compares = compares + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %0s expected %h seen %h", name, exp, got);
      end
   endtask
   task rst(input s);
      @(posedge clk);
      reset_n <= 1'b0;
      bootSelect <= s;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   // n bytes of d, highest byte first; answer bytes land in r
   task xfer(input [87:0] d, input integer n);
      r = 88'h0;
      u_mst.frameOpen;
      for (k = n - 1; k >= 0; k = k - 1) begin
         u_mst.xbyte(d[8*k +: 8], b);
         r = {r[79:0], b};
      end
      u_mst.frameClose;
   endtask
   task waitPulse(input app);
      k = 0;
      while (k < 40 && (app ? apps === seenA : starts === seenS)) begin
         @(posedge clk);
         k = k + 1;
      end
      chk("startPulse", seenS + {23'h0, ~app}, starts);
      chk("appPulse", seenA + {23'h0, app}, apps);
      seenS = starts;
      seenA = apps;
   endtask
   task finishCmd(input [23:0] v);
      @(posedge clk);
      coreDone <= 1'b1;
      coreReadData <= v;
      @(posedge clk);
      coreDone <= 1'b0;
      @(posedge clk);
      chk("pending", 24'h0, coreCmdPending);
      chk("ready", 24'h0, readyPulseN);
      repeat (24) @(posedge clk);
      chk("readyEnd", 24'h1, readyPulseN);
   endtask
   task tWrite;
      chk("boot", 24'h1, mcuBootMode);
      chk("eeSel", 24'h1, eepromSelectN);
      xfer({8'h02, 8'h03, 24'h000001, 24'h123456, 24'habcdef}, 11);
      waitPulse(1'b0);
      chk("cmd", 24'h000001, coreCommand);
      chk("dat1", 24'h123456, coreDataFirst);
      chk("dat2", 24'habcdef, coreDataSecond);
      xfer({8'h03, 8'h01, 8'h00}, 3);
      chk("busyRd", 24'h01, r[7:0]);
      finishCmd(24'h000000);
      chk("dat1Keep", 24'h123456, coreDataFirst);
      xfer({8'h03, 8'h01, 8'h00}, 3);
      chk("freeRd", 24'h00, r[7:0]);
      $display("test write done");
   endtask
   task tReadReg;
      xfer({8'h02, 8'h03, 24'h000002, 24'h000020}, 8);
      waitPulse(1'b0);
      finishCmd(24'h070431);
      xfer({8'h03, 8'h06, 24'h000000}, 5);
      chk("dat1Rd", 24'h070431, r[23:0]);
      $display("test read done");
   endtask
   task tAppend;
      xfer({8'h02, 8'h06, 24'h825e4f, 24'h83694f}, 8);
      waitPulse(1'b1);
      chk("appDat1", 24'h825e4f, coreDataFirst);
      chk("appDat2", 24'h83694f, coreDataSecond);
      chk("appCmd", 24'h000002, coreCommand);
      chk("appPend", 24'h1, coreCmdPending);
      $display("test append done");
   endtask
   task tRefuse;
      xfer({8'h02, 8'h00, 24'ha5b6c7}, 5);
      chk("ctrl", 24'ha5b7c7, coreControl);
      xfer({8'h03, 8'h01, 8'h00}, 3);
      chk("ctrlMid", 24'hb7, r[7:0]);
      xfer({8'h05, 8'h03, 24'hffffff}, 5);
      chk("badOp", 24'h000002, coreCommand);
      chk("noStart", seenS, starts);
      chk("noApp", seenA, apps);
      xfer({8'h03, 8'h0c, 8'h00}, 3);
      chk("outMap", 24'h00, r[7:0]);
      rst(1'b1);
      xfer({8'h02, 8'h03, 24'h000001}, 5);
      chk("strapHi", 24'h0, mcuBootMode);
      chk("noCmd", 24'h000000, coreCommand);
      chk("strapStart", seenS, starts);
      $display("test refuse done");
   endtask
   task summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         miscompares = miscompares + 1;
         summarize;
      end
   end
   initial begin
      rst(1'b0);
      tWrite;
      tReadReg;
      tAppend;
      tRefuse;
      summarize;
   end
endmodule
